// *** hdl/ivd_dispatch.sv ***
// Vector dispatch, reset cause capture and start-up signature reader.
// Assumes event inputs are single-cycle pulses on core_clk and memory answers via mem_ack.
`timescale 1ns/100ps

// Contract
// - At start-up the program start address is read from word 0FFFEh.
// - Vectors sit in words up to 0FFFEh; region spans 0FF80h to 0FFFFh.
// - Servicing loads the program counter from the winner's vector word.
// - Higher vector address wins; reset highest, cipher-ready at 0FFC6h lowest.
// - All listed reset causes restart through the top vector.
// - Instruction fetch from peripheral space raises a reset.
// - System NMI sources use 0FFFCh; external NMI and oscillator fault 0FFFAh.
// - NMI classes obey their own enables but ignore global enable.
// - Serial A units share a vector; sources depend on SPI or UART mode.
// - Serial B units share a vector; sources depend on I2C or SPI mode.
// - Matching signature enables words 0FFE0h..0FFFFh as loader password.
// - Signatures are read upward from 0FF80h: debug, loader, encapsulation.
// - Signatures are read and acted on before the application starts.
// - Debug password starts at 0FF88h, length chosen by debug signature.
module ivd_dispatch (
  input  wire logic                           core_clk,
  input  wire logic                           rst_b,
  input  wire logic [ivd_pkg::NUM_REVT-1:0]   rst_event,
  input  wire logic                           rst_pin_b,
  input  wire logic                           fetch_valid,
  input  wire logic [15:0]                    fetch_addr,
  input  wire logic [ivd_pkg::NUM_SNMI-1:0]   snmi_event,
  input  wire logic [ivd_pkg::NUM_SNMI-1:0]   snmi_en,
  input  wire logic                           ext_nmi_pin,
  input  wire logic                           osc_fault,
  input  wire logic [ivd_pkg::NUM_UNMI-1:0]   unmi_en,
  input  wire logic                           gie,
  input  wire logic [ivd_pkg::NUM_LINES-1:0]  line_flags,
  input  wire logic [ivd_pkg::NUM_LINES-1:0]  line_en,
  input  wire logic [1:0][3:0]                ser_a_flags,
  input  wire logic [1:0]                     ser_a_uart,
  input  wire logic [1:0][13:0]               ser_b_flags,
  input  wire logic [1:0]                     ser_b_i2c,
  input  wire logic [3:0][7:0]                port_flags,
  input  wire logic                           intr_ack,
  input  wire logic                           idx_rd,
  input  wire logic [1:0]                     idx_sel,
  input  wire logic                           mem_ack,
  input  wire logic [15:0]                    mem_rdata,
  output logic                                sys_reset,
  output logic                                mem_rd,
  output logic [15:0]                         mem_addr,
  output logic                                pc_load,
  output logic [15:0]                         pc_value,
  output logic                                irq_pending,
  output logic [15:0]                         irq_vector,
  output logic                                idx_valid,
  output logic [15:0]                         idx_data,
  output logic [ivd_pkg::NUM_RST-1:0]         rst_flags,
  output logic                                boot_done,
  output ivd_pkg::ivd_sigs_t                  sigs,
  output ivd_pkg::ivd_boot_t                  boot_cfg
);

  typedef struct packed {
    ivd_pkg::ivd_state_t             st;
    logic [2:0]                      cnt;
    ivd_pkg::ivd_sigs_t              sig;
    ivd_pkg::ivd_boot_t              cfg;
    logic [1:0]                      rsync;
    logic [1:0]                      nsync;
    logic                            nmi_seen;
    logic [ivd_pkg::NUM_RST-1:0]     rflags;
    logic [ivd_pkg::NUM_SNMI-1:0]    sflags;
    logic [ivd_pkg::NUM_UNMI-1:0]    uflags;
    logic                            sys_reset;
    logic                            mem_rd;
    logic [15:0]                     mem_addr;
    logic                            pc_load;
    logic [15:0]                     pc_value;
    logic                            irq_pending;
    logic [15:0]                     irq_vector;
    logic                            idx_valid;
    logic [15:0]                     idx_data;
    logic                            boot_done;
  } ivd_core_t;

  localparam ivd_core_t CORE_RST = '{
    st: ivd_pkg::IVD_SIG_RD, rflags: ivd_pkg::RST_FLAGS_RST, default: '0};

  ivd_core_t                         cur;
  ivd_core_t                         nx;
  logic [ivd_pkg::NUM_RST-1:0]       rst_set;
  logic [ivd_pkg::NUM_UNMI-1:0]      unmi_set;
  logic [ivd_pkg::NUM_SNMI-1:0]      snmi_req;
  logic [ivd_pkg::NUM_UNMI-1:0]      unmi_req;
  logic [ivd_pkg::NUM_LINES-1:0]     line_req;
  logic [5:0]                        pick;
  logic [31:0]                       clr;
  logic                              fetch_bad;

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------
  // One-based position of the lowest set bit, zero when none is set
  function automatic logic [5:0] first_idx(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = 6'(i + 1);
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] onehot(input logic [5:0] p);
    return (p == 6'h00) ? 32'h0 : (32'h1 << (p - 6'h01));
  endfunction

  // --------------------------------------------------------------------------
  // Request gathering
  // --------------------------------------------------------------------------
  always_comb begin
    snmi_req = cur.sflags & snmi_en;
    unmi_req = cur.uflags & unmi_en;
    line_req = line_flags;
    line_req[ivd_pkg::LINE_A0] = |(ser_a_flags[0] & (ser_a_uart[0] ? 4'hF : 4'h3));
    line_req[ivd_pkg::LINE_A1] = |(ser_a_flags[1] & (ser_a_uart[1] ? 4'hF : 4'h3));
    line_req[ivd_pkg::LINE_B0] = |(ser_b_flags[0] & (ser_b_i2c[0] ? 14'h3FFF : 14'h0003));
    line_req[ivd_pkg::LINE_B1] = |(ser_b_flags[1] & (ser_b_i2c[1] ? 14'h3FFF : 14'h0003));
    line_req[ivd_pkg::LINE_P1] = |port_flags[0];
    line_req[ivd_pkg::LINE_P2] = |port_flags[1];
    line_req[ivd_pkg::LINE_P3] = |port_flags[2];
    line_req[ivd_pkg::LINE_P4] = |port_flags[3];
    line_req = line_req & line_en & {ivd_pkg::NUM_LINES{gie}};
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    nx = cur;
    nx.rsync = {cur.rsync[0], ~rst_pin_b};
    nx.nsync = {cur.nsync[0], ext_nmi_pin};
    nx.nmi_seen = cur.nsync[1];
    nx.sys_reset = 1'b0;
    nx.mem_rd = 1'b0;
    nx.pc_load = 1'b0;
    nx.idx_valid = 1'b0;
    fetch_bad = fetch_valid && (fetch_addr < ivd_pkg::PERIPH_END);
    rst_set = {fetch_bad, cur.rsync[1], rst_event};
    unmi_set = {osc_fault, cur.nsync[1] & ~cur.nmi_seen};
    pick = 6'h00;
    if (idx_rd) begin
      case (idx_sel)
        2'h0:    pick = first_idx(32'(cur.rflags));
        2'h1:    pick = first_idx(32'(cur.sflags));
        2'h2:    pick = first_idx(32'(cur.uflags));
        default: pick = 6'h00;
      endcase
      nx.idx_valid = 1'b1;
      nx.idx_data = {9'h000, pick, 1'b0};
    end
    clr = onehot(pick);
    // Set wins over a clear in the same cycle
    nx.rflags = (cur.rflags & ~((idx_sel == 2'h0) ? clr[ivd_pkg::NUM_RST-1:0] : '0)) | rst_set;
    nx.sflags = (cur.sflags & ~((idx_sel == 2'h1) ? clr[ivd_pkg::NUM_SNMI-1:0] : '0))
              | snmi_event;
    nx.uflags = (cur.uflags & ~((idx_sel == 2'h2) ? clr[ivd_pkg::NUM_UNMI-1:0] : '0))
              | unmi_set;

    nx.irq_pending = 1'b0;
    if (|snmi_req) begin
      nx.irq_pending = 1'b1;
      nx.irq_vector = ivd_pkg::VEC_SYS_NMI;
    end else if (|unmi_req) begin
      nx.irq_pending = 1'b1;
      nx.irq_vector = ivd_pkg::VEC_USER_NMI;
    end else if (|line_req) begin
      nx.irq_pending = 1'b1;
      nx.irq_vector = ivd_pkg::VEC_LINE0
                    - {9'h000, first_idx(32'(line_req)) - 6'h01, 1'b0};
    end

    case (cur.st)
      ivd_pkg::IVD_SIG_RD: begin
        nx.mem_rd = 1'b1;
        nx.mem_addr = ivd_pkg::SIG_BASE + {12'h000, cur.cnt, 1'b0};
        nx.st = ivd_pkg::IVD_SIG_WT;
      end
      ivd_pkg::IVD_SIG_WT: begin
        if (mem_ack) begin
          nx.sig[cur.cnt] = mem_rdata;
          nx.cnt = cur.cnt + 3'h1;
          nx.st = (cur.cnt == ivd_pkg::SIG_LAST) ? ivd_pkg::IVD_RST_RD : ivd_pkg::IVD_SIG_RD;
        end
      end
      ivd_pkg::IVD_RST_RD: begin
        nx.cfg.bsl_pw_en = (cur.sig[3] == ivd_pkg::BSL_SIG_ON);
        nx.cfg.encap_en = (cur.sig[4] == ivd_pkg::ENCAP_MAGIC);
        nx.cfg.dbg_pw_words = 6'h00;
        if (cur.sig[0] == ivd_pkg::DBG_SIG_PW) begin
          nx.cfg.dbg_pw_words = (cur.sig[1] > 16'(ivd_pkg::DBG_PW_MAX)) ?
                                ivd_pkg::DBG_PW_MAX : cur.sig[1][5:0];
        end
        nx.mem_rd = 1'b1;
        nx.mem_addr = ivd_pkg::VEC_RESET;
        nx.st = ivd_pkg::IVD_RST_WT;
      end
      ivd_pkg::IVD_RST_WT: begin
        if (mem_ack) begin
          nx.pc_load = 1'b1;
          nx.pc_value = mem_rdata;
          nx.boot_done = 1'b1;
          nx.st = ivd_pkg::IVD_RUN;
        end
      end
      ivd_pkg::IVD_RUN: begin
        if (intr_ack && cur.irq_pending) begin
          nx.mem_rd = 1'b1;
          nx.mem_addr = cur.irq_vector;
          nx.st = ivd_pkg::IVD_IRQ_WT;
        end
      end
      ivd_pkg::IVD_IRQ_WT: begin
        if (mem_ack) begin
          nx.pc_load = 1'b1;
          nx.pc_value = mem_rdata;
          nx.st = ivd_pkg::IVD_RUN;
        end
      end
      default: nx.st = ivd_pkg::IVD_SIG_RD;
    endcase
    if (!nx.boot_done) begin
      nx.irq_pending = 1'b0;
    end

    if (|rst_set) begin
      nx.sys_reset = 1'b1;
      nx.st = ivd_pkg::IVD_SIG_RD;
      nx.cnt = 3'h0;
      nx.boot_done = 1'b0;
      nx.irq_pending = 1'b0;
      nx.mem_rd = 1'b0;
      nx.pc_load = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= CORE_RST;
    end else begin
      cur <= nx;
    end
  end

  assign sys_reset   = cur.sys_reset;
  assign mem_rd      = cur.mem_rd;
  assign mem_addr    = cur.mem_addr;
  assign pc_load     = cur.pc_load;
  assign pc_value    = cur.pc_value;
  assign irq_pending = cur.irq_pending;
  assign irq_vector  = cur.irq_vector;
  assign idx_valid   = cur.idx_valid;
  assign idx_data    = cur.idx_data;
  assign rst_flags   = cur.rflags;
  assign boot_done   = cur.boot_done;
  assign sigs        = cur.sig;
  assign boot_cfg    = cur.cfg;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  property p_rst_vec;
    cur.mem_rd && cur.st == ivd_pkg::IVD_RST_WT |-> cur.mem_addr == ivd_pkg::VEC_RESET;
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("start read not at top word");

  property p_vec_range;
    cur.irq_pending |-> cur.irq_vector >= ivd_pkg::VEC_LAST && !cur.irq_vector[0]
                        && cur.irq_vector <= ivd_pkg::VEC_SYS_NMI;
  endproperty
  a_vec_range: assert property (p_vec_range) else $error("vector outside table");

  property p_pc_load;
    cur.st == ivd_pkg::IVD_IRQ_WT && mem_ack && !(|rst_set)
      |=> cur.pc_load && cur.pc_value == $past(mem_rdata);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("handler address not loaded");

  property p_snmi_top;
    cur.boot_done && (|snmi_req) && !(|rst_set) |=> cur.irq_vector == ivd_pkg::VEC_SYS_NMI;
  endproperty
  a_snmi_top: assert property (p_snmi_top) else $error("system NMI lost priority");

  // A cause that stays up for several cycles keeps the restart parked
  property p_reset;
    (|rst_set) |=> cur.sys_reset && !cur.boot_done;
  endproperty
  a_reset: assert property (p_reset) else $error("reset cause did not restart");

  property p_restart;
    (|rst_set) ##1 !(|rst_set) |=> cur.mem_rd && cur.mem_addr == ivd_pkg::SIG_BASE;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not reread signatures");

  property p_fetch;
    fetch_bad |=> cur.sys_reset && cur.rflags[ivd_pkg::RC_FETCH];
  endproperty
  a_fetch: assert property (p_fetch) else $error("peripheral fetch not reset");

  property p_nmi_gie;
    cur.boot_done && !gie && !(|snmi_req) && (|unmi_req) && !(|rst_set)
      |=> cur.irq_pending && cur.irq_vector == ivd_pkg::VEC_USER_NMI;
  endproperty
  a_nmi_gie: assert property (p_nmi_gie) else $error("user NMI blocked by gie");

  property p_gie_mask;
    !gie && !(|snmi_req) && !(|unmi_req) |=> !cur.irq_pending;
  endproperty
  a_gie_mask: assert property (p_gie_mask) else $error("masked line pending");

  // Lowest flag bit is the highest priority index and is cleared by the read
  property p_idx;
    idx_rd && idx_sel == 2'h1 && cur.sflags[0] && !snmi_event[0]
      |=> cur.idx_valid && cur.idx_data == 16'h0002 && !cur.sflags[0];
  endproperty
  a_idx: assert property (p_idx) else $error("index answer wrong");

  property p_sig_first;
    cur.mem_rd && cur.st == ivd_pkg::IVD_SIG_WT |-> !cur.boot_done
      && cur.mem_addr[15:4] == ivd_pkg::SIG_BASE[15:4];
  endproperty
  a_sig_first: assert property (p_sig_first) else $error("signature read misplaced");

  c_boot: cover property (cur.pc_load && cur.st == ivd_pkg::IVD_RUN && $past(!cur.boot_done));
  c_irq: cover property (cur.st == ivd_pkg::IVD_IRQ_WT ##[1:4] cur.pc_load);
  c_idx: cover property (idx_rd && idx_sel == 2'h1 && pick != 6'h00);
  c_rst: cover property (cur.sys_reset && cur.rflags[ivd_pkg::RC_PIN]);
endmodule

// *** hdl/ivd_pkg.sv ***
// Constants and types shared by the vector dispatch block.
// Assumes a 16-bit word memory read port and on-clock event pulses from peripherals.
package ivd_pkg;
  // --------------------------------------------------------------------------
  // Region layout
  // --------------------------------------------------------------------------
  localparam logic [15:0] VEC_RESET    = 16'hFFFE;
  localparam logic [15:0] VEC_SYS_NMI  = 16'hFFFC;
  localparam logic [15:0] VEC_USER_NMI = 16'hFFFA;
  localparam logic [15:0] VEC_LINE0    = 16'hFFF8;
  localparam logic [15:0] VEC_LAST     = 16'hFFC6;
  localparam logic [15:0] VEC_FIRST    = 16'hFFFD;
  localparam logic [15:0] REGION_TOP   = 16'hFFFF;
  localparam logic [15:0] SIG_BASE     = 16'hFF80;
  localparam logic [15:0] BSL_PW_LO    = 16'hFFE0;
  localparam logic [15:0] DBG_PW_BASE  = 16'hFF88;
  localparam logic [15:0] ENCAP_MAGIC  = 16'hAAAA;
  // Fetches below this address fall in peripheral space
  localparam logic [15:0] PERIPH_END   = 16'h1000;
  // Signature values that switch a feature on; debug password length cap
  localparam logic [15:0] BSL_SIG_ON   = 16'h5A5A;
  localparam logic [15:0] DBG_SIG_PW   = 16'h5555;
  localparam logic [5:0]  DBG_PW_MAX   = 6'h3C;

  // --------------------------------------------------------------------------
  // Source counts and positions
  // --------------------------------------------------------------------------
  localparam int NUM_LINES = 26;
  localparam int NUM_SIGS  = 6;
  localparam int NUM_REVT  = 9;
  localparam int NUM_RST   = 11;
  localparam int NUM_SNMI  = 6;
  localparam int NUM_UNMI  = 2;
  localparam int RC_PIN    = 9;
  localparam int RC_FETCH  = 10;
  localparam int LINE_A0   = 5;
  localparam int LINE_B0   = 6;
  localparam int LINE_A1   = 10;
  localparam int LINE_B1   = 11;
  localparam int LINE_P1   = 15;
  localparam int LINE_P2   = 18;
  localparam int LINE_P3   = 21;
  localparam int LINE_P4   = 22;
  localparam logic [NUM_RST-1:0] RST_FLAGS_RST = 11'h001;
  localparam logic [2:0] SIG_LAST = 3'h5;

  typedef enum logic [2:0] {
    IVD_SIG_RD, IVD_SIG_WT, IVD_RST_RD, IVD_RST_WT, IVD_RUN, IVD_IRQ_WT
  } ivd_state_t;

  typedef logic [NUM_SIGS-1:0][15:0] ivd_sigs_t;

  typedef struct packed {
    logic       bsl_pw_en;
    logic       encap_en;
    logic [5:0] dbg_pw_words;
  } ivd_boot_t;
endpackage

// *** verification/ivd_mem_model.sv ***
// Word memory model for the vector and signature region.
// Assumes one read in flight; slow adds three wait cycles.
`timescale 1ns/100ps
module ivd_mem_model (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  input  wire logic        slow,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  logic [15:0] addr_q;
  logic [1:0]  wait_q;
  logic        busy_q;

  // encapsulation wanted, so its marker is legal here
  function automatic logic [15:0] word_at(input logic [15:0] a);
    case (a)
      16'hFF80: word_at = ivd_pkg::DBG_SIG_PW;
      16'hFF82: word_at = 16'h0040;
      16'hFF86: word_at = ivd_pkg::BSL_SIG_ON;
      16'hFF88: word_at = ivd_pkg::ENCAP_MAGIC;
      16'hFF8A: word_at = 16'h1234;
      default:  word_at = {8'hC0, a[7:0]};
    endcase
  endfunction

  // Data toggles when not answering, so stale words never look valid
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      {mem_ack, busy_q, wait_q, addr_q, mem_rdata} <= '0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_rd) begin
        busy_q <= 1'b1;
        addr_q <= mem_addr;
        wait_q <= slow ? 2'h3 : 2'h0;
      end else if (busy_q && wait_q == 2'h0) begin
        mem_ack <= 1'b1;
        mem_rdata <= word_at(addr_q);
        busy_q <= 1'b0;
      end else if (busy_q) begin
        wait_q <= wait_q - 2'h1;
      end
    end
  end
endmodule

// *** verification/tb_interrupt_vector_dispatch.sv ***
// Self-checking bench for the vector dispatch block.
// Assumes the memory model answers boot and vector reads.
`timescale 1ns/100ps
module tb_interrupt_vector_dispatch;
  logic core_clk, rst_b, rst_pin_b, fetch_valid, ext_nmi_pin, osc_fault, gie, slow;
  logic intr_ack, idx_rd, mem_ack, sys_reset, mem_rd, pc_load, irq_pending;
  logic idx_valid, boot_done;
  logic [8:0]       rst_event;
  logic [15:0]      fetch_addr, mem_rdata, mem_addr, pc_value, irq_vector, idx_data;
  logic [5:0]       snmi_event, snmi_en;
  logic [1:0]       unmi_en, ser_a_uart, ser_b_i2c, idx_sel;
  logic [25:0]      line_flags, line_en;
  logic [1:0][3:0]  ser_a_flags;
  logic [1:0][13:0] ser_b_flags;
  logic [3:0][7:0]  port_flags;
  logic [10:0]      rst_flags;
  ivd_pkg::ivd_sigs_t sigs;
  ivd_pkg::ivd_boot_t boot_cfg;
  int               miscompares, check_count;
  logic [15:0]      seq[$];

  ivd_dispatch ivd_dispatch_inst (
    .core_clk(core_clk), .rst_b(rst_b), .rst_event(rst_event), .rst_pin_b(rst_pin_b),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .snmi_event(snmi_event),
    .snmi_en(snmi_en), .ext_nmi_pin(ext_nmi_pin), .osc_fault(osc_fault), .unmi_en(unmi_en),
    .gie(gie), .line_flags(line_flags), .line_en(line_en), .ser_a_flags(ser_a_flags),
    .ser_a_uart(ser_a_uart), .ser_b_flags(ser_b_flags), .ser_b_i2c(ser_b_i2c),
    .port_flags(port_flags), .intr_ack(intr_ack), .idx_rd(idx_rd), .idx_sel(idx_sel),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .sys_reset(sys_reset), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .pc_load(pc_load), .pc_value(pc_value), .irq_pending(irq_pending),
    .irq_vector(irq_vector), .idx_valid(idx_valid), .idx_data(idx_data),
    .rst_flags(rst_flags), .boot_done(boot_done), .sigs(sigs), .boot_cfg(boot_cfg));

  ivd_mem_model ivd_mem_model_inst (
    .core_clk(core_clk), .rst_b(rst_b), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (mem_rd === 1'b1) seq.push_back(mem_addr);
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic flag(input int s);
    case (s)
      0: flag = boot_done;
      1: flag = irq_pending;
      2: flag = pc_load;
      default: flag = sys_reset;
    endcase
  endfunction

  // Bounded wait; a timeout ends the run
  task automatic await(input int s);
    for (int i = 0; i < 300; i++) begin
      @(posedge core_clk);
      #1;
      if (flag(s) === 1'b1) begin
        @(negedge core_clk);
        return;
      end
    end
    miscompares++;
    $display("MISMATCH wait %0d expected 1 seen timeout", s);
    complete_run();
  endtask

  task automatic boot_check();
    await(0);
    chk("pc_value", pc_value, ivd_mem_model_inst.word_at(ivd_pkg::VEC_RESET));
    for (int i = 0; i < 6; i++) begin
      chk("sigs", sigs[i], ivd_mem_model_inst.word_at(16'hFF80 + 16'(2 * i)));
    end
    chk("boot_cfg", 16'(boot_cfg), 16'h00FC);
  endtask

  task automatic exp_irq(input logic pend, input logic [15:0] vec);
    repeat (3) @(negedge core_clk);
    chk("irq_pending", 16'(irq_pending), 16'(pend));
    if (pend) chk("irq_vector", irq_vector, vec);
  endtask

  task automatic idx(input logic [1:0] sel, input logic [15:0] exp);
    @(negedge core_clk);
    idx_rd = 1'b1;
    idx_sel = sel;
    @(negedge core_clk);
    idx_rd = 1'b0;
    chk("idx_valid", 16'(idx_valid), 16'h0001);
    chk("idx_data", idx_data, exp);
  endtask

  task automatic service(input logic [15:0] vec);
    await(1);
    @(negedge core_clk);
    intr_ack = 1'b1;
    @(negedge core_clk);
    intr_ack = 1'b0;
    await(2);
    chk("mem_addr", mem_addr, vec);
    chk("pc_value", pc_value, ivd_mem_model_inst.word_at(vec));
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_b, fetch_valid, ext_nmi_pin, osc_fault, slow, intr_ack, idx_rd, idx_sel} = '0;
    {rst_event, snmi_event, line_flags, ser_a_flags, ser_b_flags, port_flags} = '0;
    {ser_a_uart, ser_b_i2c, gie} = '0;
    {snmi_en, unmi_en, line_en} = '1;
    rst_pin_b = 1'b1;
    fetch_addr = 16'h1000;
    repeat (3) @(negedge core_clk);
    chk("rst_flags", 16'(rst_flags), 16'h0001);
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    boot_check();
    for (int i = 0; i < 7; i++) chk("order", seq[i], i < 6 ? 16'hFF80 + 16'(2 * i) : 16'hFFFE);
    line_flags[0] = 1'b1;
    exp_irq(1'b0, 16'h0000);
    gie = 1'b1;
    line_en[0] = 1'b0;
    exp_irq(1'b0, 16'h0000);
    line_en[0] = 1'b1;
    exp_irq(1'b1, 16'hFFF8);
    snmi_event = 6'h3F;
    osc_fault = 1'b1;
    @(negedge core_clk);
    {snmi_event, osc_fault} = '0;
    exp_irq(1'b1, 16'hFFFC);
    gie = 1'b0;
    exp_irq(1'b1, 16'hFFFC);
    snmi_en = '0;
    exp_irq(1'b1, 16'hFFFA);
    unmi_en = '0;
    exp_irq(1'b0, 16'h0000);
    {snmi_en, unmi_en, gie} = '1;
    for (int i = 0; i < 6; i++) idx(2'h1, 16'(2 * (i + 1)));
    idx(2'h1, 16'h0000);
    exp_irq(1'b1, 16'hFFFA);
    ext_nmi_pin = 1'b1;
    repeat (4) @(negedge core_clk);
    idx(2'h2, 16'h0002);
    idx(2'h2, 16'h0004);
    idx(2'h2, 16'h0000);
    exp_irq(1'b1, 16'hFFF8);
    service(16'hFFF8);
    line_flags = '0;
    ser_a_flags[0][2] = 1'b1;
    exp_irq(1'b0, 16'h0000);
    ser_a_uart[0] = 1'b1;
    exp_irq(1'b1, 16'hFFEE);
    ser_a_flags = '0;
    ser_a_flags[1][1] = 1'b1;
    exp_irq(1'b1, 16'hFFE4);
    ser_a_flags = '0;
    ser_b_flags[0][13] = 1'b1;
    exp_irq(1'b0, 16'h0000);
    ser_b_i2c[0] = 1'b1;
    exp_irq(1'b1, 16'hFFEC);
    ser_b_flags = '0;
    ser_b_flags[1][0] = 1'b1;
    exp_irq(1'b1, 16'hFFE2);
    ser_b_flags = '0;
    port_flags[0][7] = 1'b1;
    port_flags[3][0] = 1'b1;
    exp_irq(1'b1, 16'hFFDA);
    port_flags[0] = '0;
    exp_irq(1'b1, 16'hFFCC);
    port_flags = '0;
    line_flags[25] = 1'b1;
    service(16'hFFC6);
    line_flags = '0;
    // Restarts below run with a slow memory
    slow = 1'b1;
    fetch_valid = 1'b1;
    exp_irq(1'b0, 16'h0000);
    chk("fetch flag", 16'(rst_flags[10]), 16'h0000);
    fetch_valid = 1'b0;
    for (int k = 1; k < 9; k++) begin
      rst_event = 9'(1 << k);
      await(3);
      rst_event = '0;
      chk("cause flag", 16'(rst_flags[k]), 16'h0001);
      boot_check();
    end
    rst_pin_b = 1'b0;
    repeat (3) @(negedge core_clk);
    rst_pin_b = 1'b1;
    await(3);
    chk("pin flag", 16'(rst_flags[9]), 16'h0001);
    boot_check();
    @(negedge core_clk);
    fetch_addr = 16'h0FFE;
    fetch_valid = 1'b1;
    await(3);
    fetch_valid = 1'b0;
    chk("fetch flag", 16'(rst_flags[10]), 16'h0001);
    boot_check();
    for (int i = 0; i < 11; i++) idx(2'h0, 16'(2 * (i + 1)));
    idx(2'h0, 16'h0000);
    idx(2'h3, 16'h0000);
    complete_run();
  end
endmodule
